/* rtl/input_ov_pkg.sv */
package input_ov_pkg;

  // command codes of the three registers
  localparam logic [7:0]  CMD_FAULT_LIMIT    = 8'h55;
  localparam logic [7:0]  CMD_FAULT_RESP     = 8'h56;
  localparam logic [7:0]  CMD_WARN_LIMIT     = 8'h57;

  // reset values; limits in Linear-11 (N=-1: 15.0 V and 14.5 V)
  localparam logic [15:0] FAULT_LIMIT_RST    = 16'hF81E;
  localparam logic [7:0]  FAULT_RESP_RST     = 8'hB8;
  localparam logic [15:0] WARN_LIMIT_RST     = 16'hF81D;

  // Linear-11 fields
  localparam int          EXP_MSB            = 15;
  localparam int          EXP_LSB            = 11;
  localparam int          MANT_MSB           = 10;
  localparam int          MANT_LSB           = 0;

  // fault response fields
  localparam int          RESP_MODE_MSB      = 7;
  localparam int          RESP_MODE_LSB      = 6;
  localparam int          RETRY_MSB          = 5;
  localparam int          RETRY_LSB          = 3;
  localparam int          DELAY_MSB          = 2;
  localparam int          DELAY_LSB          = 0;
  localparam logic [1:0]  RESP_DISABLE_RETRY = 2'h2;
  localparam logic [2:0]  RETRY_NONE         = 3'h0;

  // accepted limit range in volts
  localparam int          LIMIT_MIN_V        = 0;
  localparam int          LIMIT_MAX_V        = 18;

  // fixed-point scaling: internal 2^-16 V, measured input 2^-8 V
  localparam int          FIX_FRAC           = 16;
  localparam int          VIN_FRAC           = 8;
  localparam int          FIX_W              = 48;

  // retry delay step
  localparam int unsigned RETRY_UNIT_MS      = 35;
  localparam int unsigned CLK_KHZ            = 100000;
  localparam int unsigned RETRY_UNIT_CYCLES  = RETRY_UNIT_MS * CLK_KHZ;

  // status bit positions
  localparam int          SW_NOTA_BIT        = 0;
  localparam int          SW_INPUT_BIT       = 13;
  localparam int          SI_OV_FAULT_BIT    = 7;
  localparam int          SI_OV_WARN_BIT     = 6;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HOLD = 2'b01,
    ST_WAIT = 2'b10
  } ov_state_t;

endpackage : input_ov_pkg

/* rtl/ov_cmp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ov_cmp_if;
  logic [15:0] fault_limit;
  logic [15:0] warn_limit;
  logic [15:0] vin;
  logic [15:0] wdata;
  logic        above_fault;
  logic        above_warn;
  logic        wdata_in_range;

  modport ctrl (output fault_limit, output warn_limit, output vin,
                output wdata, input above_fault, input above_warn,
                input wdata_in_range);
  modport cmp  (input fault_limit, input warn_limit, input vin,
                input wdata, output above_fault, output above_warn,
                output wdata_in_range);
endinterface : ov_cmp_if
`default_nettype wire

/* rtl/ov_lin11_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module ov_lin11_compare (
  ov_cmp_if.cmp c
);

  localparam int W = input_ov_pkg::FIX_W;

  // Linear-11 word to signed fixed point, 2^-16 V per lsb
  function automatic logic signed [W-1:0] lin11_to_fix(
    input logic [15:0] v
  );
    logic signed [4:0]   n;
    logic signed [W-1:0] y;
    logic signed [6:0]   sh;
    n  = v[input_ov_pkg::EXP_MSB:input_ov_pkg::EXP_LSB];
    y  = W'(signed'(v[input_ov_pkg::MANT_MSB:input_ov_pkg::MANT_LSB]));
    sh = 7'(n) + 7'(input_ov_pkg::FIX_FRAC);
    lin11_to_fix = y <<< sh[5:0];
  endfunction : lin11_to_fix

  logic signed [W-1:0] vin_fix;
  logic signed [W-1:0] wr_fix;

  assign vin_fix = W'({c.vin, 8'h00});
  assign wr_fix  = lin11_to_fix(c.wdata); // RULE1

  assign c.above_fault = vin_fix > lin11_to_fix(c.fault_limit); // RULE1
  assign c.above_warn  = vin_fix > lin11_to_fix(c.warn_limit);  // RULE1
  assign c.wdata_in_range =
    (wr_fix >= W'(input_ov_pkg::LIMIT_MIN_V * (1 << input_ov_pkg::FIX_FRAC)))
    && (wr_fix <= W'(input_ov_pkg::LIMIT_MAX_V
                     * (1 << input_ov_pkg::FIX_FRAC))); // RULE2

endmodule : ov_lin11_compare
`default_nettype wire

/* rtl/input_overvoltage_fault_control.sv */
// What this block does
// RULE1: limits are Linear-11: 5-bit signed exponent, 11-bit signed mantissa.
// RULE2: limit writes outside 0 V to 18 V are refused.
// RULE3: a retry waits until input falls below the warning limit.
// RULE4: host keeps the warning limit below the fault limit.
// RULE5: response bits 7:6 = 10 disables and retries; other codes unused.
// RULE6: input above fault limit flags a fault and applies the response; code does this only in ST_RUN with output_on_req high and other_shutdown low.
// RULE7: input above warning limit raises a warning; limit resets to 14.5 V.
// RULE8: warning sets status word bits, status input bit, and alerts host.
// RULE9: a fault pulls the alert low; its bit clears only on clear faults.
// RULE10: retry field 000 keeps output off until the device restarts.
// RULE11: nonzero retry field retries until disabled or another fault.
// RULE12: attempts are spaced (delay field + 1) times 35 ms.
// RULE13: a refused write keeps the old value and reports a data error.
`timescale 1ns/1ps
`default_nettype none
module input_overvoltage_fault_control #(
  parameter int unsigned RETRY_UNIT_CYCLES =
    input_ov_pkg::RETRY_UNIT_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        cmd_wr_en,
  input  wire logic        cmd_rd_en,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output var  logic [15:0] cmd_rdata,
  output var  logic        cmd_data_err,
  input  wire logic        clear_faults,
  input  wire logic        device_restart,
  input  wire logic        output_on_req,
  input  wire logic        other_shutdown,
  input  wire logic [15:0] vin_meas,
  output var  logic        output_enable,
  output var  logic        status_word_nota,
  output var  logic        status_word_input,
  output var  logic        status_input_ov_fault,
  output var  logic        status_input_ov_warn,
  output logic             host_alert_line_o,
  output logic             host_alert_line_oe
);

  ov_cmp_if cmp_bus ();

  ov_lin11_compare u_cmp (
    .c (cmp_bus.cmp)
  );

  logic [15:0]             fault_lim_r, fault_lim_nxt;
  logic [7:0]              resp_r,      resp_nxt;
  logic [15:0]             warn_lim_r,  warn_lim_nxt;
  input_ov_pkg::ov_state_t state_r,     state_nxt;
  logic [31:0]             dly_r,       dly_nxt;
  logic [15:0]             rdata_r,     rdata_nxt;
  logic                    err_r,       err_nxt;
  logic                    flt_r,       flt_nxt;
  logic                    wrn_r,       wrn_nxt;
  logic                    nota_r,      nota_nxt;
  logic                    inp_r,       inp_nxt;
  logic                    oe_r,        oe_nxt;

  logic [1:0]              resp_mode;
  logic [2:0]              retry_set;
  logic [2:0]              delay_set;
  logic                    fault_now;
  logic                    ok_limit;

  assign cmp_bus.fault_limit = fault_lim_r;
  assign cmp_bus.warn_limit  = warn_lim_r;
  assign cmp_bus.vin         = vin_meas;
  assign cmp_bus.wdata       = cmd_wdata;

  assign resp_mode = resp_r[input_ov_pkg::RESP_MODE_MSB:
                            input_ov_pkg::RESP_MODE_LSB]; // RULE5
  assign retry_set = resp_r[input_ov_pkg::RETRY_MSB:input_ov_pkg::RETRY_LSB];
  assign delay_set = resp_r[input_ov_pkg::DELAY_MSB:input_ov_pkg::DELAY_LSB];
  assign ok_limit  = cmp_bus.wdata_in_range;

  // fault is only judged while the output is running
  assign fault_now = cmp_bus.above_fault && (state_r == input_ov_pkg::ST_RUN)
                     && output_on_req && !other_shutdown; // RULE6

  always_comb begin
    fault_lim_nxt = fault_lim_r;
    resp_nxt      = resp_r;
    warn_lim_nxt  = warn_lim_r;
    state_nxt     = state_r;
    dly_nxt       = dly_r;
    rdata_nxt     = rdata_r;
    err_nxt       = 1'b0;

    // register writes
    if (cmd_wr_en) begin
      case (cmd_code)
        input_ov_pkg::CMD_FAULT_LIMIT: begin
          if (ok_limit) begin // RULE2
            fault_lim_nxt = cmd_wdata;
          end else begin
            err_nxt = 1'b1; // RULE13
          end
        end
        input_ov_pkg::CMD_FAULT_RESP: begin
          resp_nxt = cmd_wdata[7:0];
        end
        input_ov_pkg::CMD_WARN_LIMIT: begin
          if (ok_limit) begin // RULE2
            warn_lim_nxt = cmd_wdata;
          end else begin
            err_nxt = 1'b1; // RULE13
          end
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end

    // register reads, answered one cycle later
    if (cmd_rd_en) begin
      case (cmd_code)
        input_ov_pkg::CMD_FAULT_LIMIT: rdata_nxt = fault_lim_r;
        input_ov_pkg::CMD_FAULT_RESP:  rdata_nxt = {8'h00, resp_r};
        input_ov_pkg::CMD_WARN_LIMIT:  rdata_nxt = warn_lim_r;
        default: begin
          rdata_nxt = 16'h0000;
          err_nxt   = 1'b1;
        end
      endcase
    end

    // sticky status: set wins over clear
    flt_nxt  = (flt_r && !clear_faults) || fault_now; // RULE9
    wrn_nxt  = (wrn_r && !clear_faults) || cmp_bus.above_warn; // RULE7
    nota_nxt = (nota_r && !clear_faults) || cmp_bus.above_warn
               || fault_now; // RULE8
    inp_nxt  = (inp_r && !clear_faults) || cmp_bus.above_warn
               || fault_now; // RULE8

    // fault response sequencing
    case (state_r)
      input_ov_pkg::ST_RUN: begin
        if (fault_now && resp_mode == input_ov_pkg::RESP_DISABLE_RETRY) begin
          if (retry_set == input_ov_pkg::RETRY_NONE) begin
            state_nxt = input_ov_pkg::ST_HOLD; // RULE10
          end else begin
            state_nxt = input_ov_pkg::ST_WAIT; // RULE11
            dly_nxt   = 32'(({29'h0, delay_set} + 32'h1)
                            * RETRY_UNIT_CYCLES) - 32'h1; // RULE12
          end
        end
      end
      input_ov_pkg::ST_HOLD: begin
        if (device_restart) begin
          state_nxt = input_ov_pkg::ST_RUN; // RULE10
        end
      end
      input_ov_pkg::ST_WAIT: begin
        if (!output_on_req || other_shutdown) begin
          state_nxt = input_ov_pkg::ST_RUN; // RULE11
          dly_nxt   = 32'h0;
        end else if (dly_r != 32'h0) begin
          dly_nxt = dly_r - 32'h1; // RULE12
        end else if (!cmp_bus.above_warn) begin
          state_nxt = input_ov_pkg::ST_RUN; // RULE3
        end
      end
      default: begin
        state_nxt = input_ov_pkg::ST_RUN;
      end
    endcase

    // unused response codes flag the fault but keep the output running
    oe_nxt = (state_nxt == input_ov_pkg::ST_RUN) && output_on_req
             && !other_shutdown; // RULE5
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_lim_r <= input_ov_pkg::FAULT_LIMIT_RST;
      resp_r      <= input_ov_pkg::FAULT_RESP_RST;
      warn_lim_r  <= input_ov_pkg::WARN_LIMIT_RST; // RULE7
      state_r     <= input_ov_pkg::ST_RUN;
      dly_r       <= 32'h0;
      rdata_r     <= 16'h0000;
      err_r       <= 1'b0;
      flt_r       <= 1'b0;
      wrn_r       <= 1'b0;
      nota_r      <= 1'b0;
      inp_r       <= 1'b0;
      oe_r        <= 1'b0;
    end else begin
      fault_lim_r <= fault_lim_nxt;
      resp_r      <= resp_nxt;
      warn_lim_r  <= warn_lim_nxt;
      state_r     <= state_nxt;
      dly_r       <= dly_nxt;
      rdata_r     <= rdata_nxt;
      err_r       <= err_nxt;
      flt_r       <= flt_nxt;
      wrn_r       <= wrn_nxt;
      nota_r      <= nota_nxt;
      inp_r       <= inp_nxt;
      oe_r        <= oe_nxt;
    end
  end

  assign cmd_rdata             = rdata_r;
  assign cmd_data_err          = err_r;
  assign output_enable         = oe_r;
  assign status_word_nota      = nota_r;
  assign status_word_input     = inp_r;
  assign status_input_ov_fault = flt_r;
  assign status_input_ov_warn  = wrn_r;

  // open-drain alert: driven low while any status bit stands
  assign host_alert_line_o  = 1'b0;
  assign host_alert_line_oe = flt_r || wrn_r; // RULE9

endmodule : input_overvoltage_fault_control
`default_nettype wire

/* tb/ov_fault_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ov_fault_chk (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       cmd_wr_en,
  input wire logic       cmd_rd_en,
  input wire logic [7:0] cmd_code,
  input wire logic       cmd_data_err,
  input wire logic       clear_faults,
  input wire logic       output_enable,
  input wire logic       status_word_nota,
  input wire logic       status_word_input,
  input wire logic       status_input_ov_fault,
  input wire logic       status_input_ov_warn,
  input wire logic       host_alert_line_o,
  input wire logic       host_alert_line_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_FLT_ALERT: assert property (
    status_input_ov_fault |-> host_alert_line_oe && !host_alert_line_o)
    else $error("fault without alert");
  AST_WARN_ALERT: assert property (
    status_input_ov_warn |-> host_alert_line_oe)
    else $error("warning without alert");
  AST_ALERT_REL: assert property (
    !status_input_ov_fault && !status_input_ov_warn |-> !host_alert_line_oe)
    else $error("alert held with no status");
  AST_WARN_WORD: assert property (
    $rose(status_input_ov_warn) |-> status_word_nota && status_word_input)
    else $error("warning without status word bits");
  AST_FLT_WORD: assert property (
    $rose(status_input_ov_fault) |-> status_word_nota && status_word_input)
    else $error("fault without status word bits");
  AST_FLT_STICKY: assert property (
    $fell(status_input_ov_fault) |-> $past(clear_faults) || $past(srst))
    else $error("fault bit dropped without clear");
  AST_WARN_STICKY: assert property (
    $fell(status_input_ov_warn) |-> $past(clear_faults) || $past(srst))
    else $error("warning bit dropped without clear");
  AST_ERR_CAUSE: assert property (
    cmd_data_err |-> $past(cmd_wr_en) || $past(cmd_rd_en))
    else $error("data error with no request");
  AST_RESP_OK: assert property (
    cmd_wr_en && cmd_code == 8'h56 |=> !cmd_data_err)
    else $error("response write refused");
  cover property ($rose(status_input_ov_fault));
  cover property ($rose(status_input_ov_warn));
  cover property ($rose(output_enable));
endmodule : ov_fault_chk
bind input_overvoltage_fault_control ov_fault_chk ov_fault_chk_i (
  .ref_clk               (ref_clk),
  .srst                  (srst),
  .cmd_wr_en             (cmd_wr_en),
  .cmd_rd_en             (cmd_rd_en),
  .cmd_code              (cmd_code),
  .cmd_data_err          (cmd_data_err),
  .clear_faults          (clear_faults),
  .output_enable         (output_enable),
  .status_word_nota      (status_word_nota),
  .status_word_input     (status_word_input),
  .status_input_ov_fault (status_input_ov_fault),
  .status_input_ov_warn  (status_input_ov_warn),
  .host_alert_line_o     (host_alert_line_o),
  .host_alert_line_oe    (host_alert_line_oe)
);
`default_nettype wire

/* tb/host_alert_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_alert_model (
  input  wire logic host_alert_line_o,
  input  wire logic host_alert_line_oe,
  output var  logic alert_n
);
  // open-drain wire with host pull-up
  assign alert_n = host_alert_line_oe ? host_alert_line_o
                                      : 1'b1;
endmodule : host_alert_model
`default_nettype wire

/* tb/input_overvoltage_fault_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module input_overvoltage_fault_control_tb;
  localparam int U = 10;
  logic        ref_clk, srst, cmd_wr_en, cmd_rd_en, clear_faults;
  logic        device_restart, output_on_req, other_shutdown, alert_n;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, vin_meas;
  logic        cmd_data_err, output_enable, status_word_nota;
  logic        status_word_input, status_input_ov_fault;
  logic        status_input_ov_warn, host_alert_line_o, host_alert_line_oe;
  int          error_cnt, cmp_count, n;
  int          mdl [int];

  input_overvoltage_fault_control #(.RETRY_UNIT_CYCLES(U))
    input_overvoltage_fault_control_i (
    .ref_clk               (ref_clk),
    .srst                  (srst),
    .cmd_wr_en             (cmd_wr_en),
    .cmd_rd_en             (cmd_rd_en),
    .cmd_code              (cmd_code),
    .cmd_wdata             (cmd_wdata),
    .cmd_rdata             (cmd_rdata),
    .cmd_data_err          (cmd_data_err),
    .clear_faults          (clear_faults),
    .device_restart        (device_restart),
    .output_on_req         (output_on_req),
    .other_shutdown        (other_shutdown),
    .vin_meas              (vin_meas),
    .output_enable         (output_enable),
    .status_word_nota      (status_word_nota),
    .status_word_input     (status_word_input),
    .status_input_ov_fault (status_input_ov_fault),
    .status_input_ov_warn  (status_input_ov_warn),
    .host_alert_line_o     (host_alert_line_o),
    .host_alert_line_oe    (host_alert_line_oe)
  );
  host_alert_model host_alert_model_i (
    .host_alert_line_o  (host_alert_line_o),
    .host_alert_line_oe (host_alert_line_oe),
    .alert_n            (alert_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(logic [7:0] c, logic [15:0] d, logic e);
    @(posedge ref_clk);
    cmd_wr_en <= 1'b1;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_wr_en <= 1'b0;
    #1 chk("err", e, cmd_data_err);
  endtask : wr

  task automatic rd(logic [7:0] c, logic [15:0] e);
    @(posedge ref_clk);
    cmd_rd_en <= 1'b1;
    cmd_code  <= c;
    @(posedge ref_clk);
    cmd_rd_en <= 1'b0;
    #1 chk("rdata", e, cmd_rdata);
  endtask : rd

  // accepted when value in 0..18 V
  function automatic logic ok_val(logic [7:0] c, logic [15:0] d);
    int x, y;
    x = $signed(d[15:11]);
    y = $signed(d[10:0]);
    if (c == 8'h56) return 1'b1;
    if (y < 0) return 1'b0;
    if (x >= 0) return (y <<< x) <= 18;
    return y <= (18 <<< -x);
  endfunction : ok_val

  task automatic wm(logic [7:0] c, logic [15:0] d);
    logic ok;
    ok = ok_val(c, d);
    if (ok) mdl[c] = (c == 8'h56) ? {8'h00, d[7:0]} : d;
    wr(c, d, !ok);
    rd(c, 16'(mdl[c]));
  endtask : wm

  task automatic wait_oe(logic v, int mx);
    n = 0;
    while (output_enable !== v) begin
      tick(1);
      n++;
      if (n > mx) begin
        chk("oe wait", v, output_enable);
        stop_test();
      end
    end
  endtask : wait_oe

  task automatic set_vin(logic [15:0] v);
    @(posedge ref_clk);
    vin_meas <= v;
    #1;
  endtask : set_vin

  task automatic clear;
    @(posedge ref_clk);
    clear_faults <= 1'b1;
    @(posedge ref_clk);
    clear_faults <= 1'b0;
    #1;
  endtask : clear

  initial begin
    srst = 1'b1;
    {cmd_wr_en, cmd_rd_en, clear_faults, device_restart} = 4'h0;
    other_shutdown = 1'b0;
    output_on_req = 1'b1;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    vin_meas = 16'h0C00;
    error_cnt = 0;
    cmp_count = 0;
    mdl[8'h55] = 16'hF81E;
    mdl[8'h56] = 16'h00B8;
    mdl[8'h57] = 16'hF81D;
    void'($urandom(32'hAD50));
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    foreach (mdl[c]) rd(c[7:0], 16'(mdl[c]));
    wr(8'h60, 16'h0000, 1'b1);
    wm(8'h57, 16'hF824);
    wm(8'h57, 16'hF825);
    wm(8'h57, 16'hFFFE);
    wm(8'h55, 16'h0013);
    wm(8'h55, 16'h0809);
    wm(8'h55, 16'hF81E);
    repeat (6) wm(8'h57, {5'h1F, 11'($urandom_range(40))});
    wm(8'h57, 16'hF81D);
    set_vin(16'h0EC0);
    tick(2);
    chk("warn", 1, status_input_ov_warn);
    chk("word", 2'b11, {status_word_nota, status_word_input});
    chk("alert", 0, alert_n);
    chk("oe", 1, output_enable);
    set_vin(16'h0C00);
    clear();
    chk("warn clr", 0, status_input_ov_warn);
    set_vin(16'h1000);
    tick(2);
    chk("flt", 1, status_input_ov_fault);
    chk("oe", 0, output_enable);
    tick(3 * U);
    chk("hold", 0, output_enable);
    set_vin(16'h0C00);
    wait_oe(1'b1, 5);
    clear();
    for (int d = 1; d < 8; d += 3) begin
      wm(8'h56, 16'h00B8 | 16'(d));
      set_vin(16'h1000);
      set_vin(16'h0C00);
      wait_oe(1'b1, 100);
      chk("gap", 1, n >= (d + 1) * U && n <= (d + 1) * U + 3);
      clear();
    end
    wm(8'h56, 16'h0080);
    set_vin(16'h1000);
    set_vin(16'h0C00);
    tick(6 * U);
    chk("latched", 0, output_enable);
    @(posedge ref_clk);
    device_restart <= 1'b1;
    @(posedge ref_clk);
    device_restart <= 1'b0;
    #1;
    wait_oe(1'b1, 5);
    clear();
    // dropping the on request aborts a long retry wait
    wm(8'h56, 16'h00BF);
    set_vin(16'h1000);
    set_vin(16'h0C00);
    @(posedge ref_clk);
    output_on_req <= 1'b0;
    tick(2);
    chk("off", 0, output_enable);
    @(posedge ref_clk);
    output_on_req <= 1'b1;
    #1;
    wait_oe(1'b1, 5);
    // another shutdown cause aborts it as well
    set_vin(16'h1000);
    set_vin(16'h0C00);
    @(posedge ref_clk);
    other_shutdown <= 1'b1;
    tick(2);
    chk("shut", 0, output_enable);
    @(posedge ref_clk);
    other_shutdown <= 1'b0;
    #1;
    wait_oe(1'b1, 5);
    clear();
    // modes 00, 01, 11
    for (int m = 0; m < 4; m += m + 1) begin
      wm(8'h56, {8'h00, 2'(m), 6'h38});
      set_vin(16'h1000);
      tick(2);
      chk("flt", 1, status_input_ov_fault);
      chk("oe", 1, output_enable);
      set_vin(16'h0C00);
      clear();
    end
    stop_test();
  end
endmodule : input_overvoltage_fault_control_tb
`default_nettype wire
